// ===== src/bfc_port_a_ctrl.sv
// port A control, port B side and bypass of the two-way fifo buffer
`timescale 1ns/1ps
module bfc_port_a_ctrl #(
  parameter int DW = bfc_pkg::DATA_W,
  parameter int DEPTH = bfc_pkg::FIFO_DEPTH,
  parameter int OW = bfc_pkg::OFFSET_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic masterResetN,
  input wire logic portAClock,
  input wire logic portASelectN,
  input wire logic portADir,
  input wire logic portAEnableN,
  input wire logic portADriveN,
  input wire logic [2:0] resourceSelect,
  input wire logic [DW-1:0] portADataIn,
  output logic [DW-1:0] portADataOut,
  output logic portADataOe,
  input wire logic portBClock,
  input wire logic portBDir,
  input wire logic portBEnableN,
  input wire logic portBDriveN,
  input wire logic [DW-1:0] portBDataIn,
  output logic [DW-1:0] portBDataOut,
  output logic portBDataOe,
  output logic bypassActiveN,
  output logic a2bEmptyN,
  output logic a2bAlmostEmptyN,
  output logic a2bFullN,
  output logic a2bAlmostFullN,
  output logic b2aEmptyN,
  output logic b2aAlmostEmptyN,
  output logic b2aFullN,
  output logic b2aAlmostFullN
);
  localparam int RSF_CYC = bfc_pkg::RESET_TO_FLAGS_CYC;

  typedef struct packed {
    logic [DW-1:0] aOut;
    logic aOe;
    logic aDir;
    logic [DW-1:0] bOut;
    logic bOe;
    logic bDir;
    logic bypassN;
    logic [DW-1:0] abWord;
    logic abFull;
    logic [DW-1:0] baWord;
    logic baFull;
    logic [3:0][OW-1:0] offs;
  } bfc_top_t;

  localparam bfc_top_t ST_RST = '{aOut: '0, aOe: 1'b0, aDir: 1'b0, bOut: '0, bOe: 1'b0,
    bDir: 1'b0, bypassN: bfc_pkg::BYPASS_N_RST, abWord: '0, abFull: 1'b0, baWord: '0,
    baFull: 1'b0, offs: {4{bfc_pkg::OFFSET_RST}}};

  bfc_top_t st;
  bfc_top_t next_st;
  logic aTick;
  logic bTick;
  logic devReset;
  logic aSel;
  logic aWrite;
  logic aRead;
  logic addrFifo;
  logic addrBypass;
  logic addrOffset;
  logic bWrite;
  logic bRead;
  logic a2bRdOk;
  logic b2aRdOk;
  logic [DW-1:0] a2bData;
  logic [DW-1:0] b2aData;
  logic [OW-1:0] offSel;

  // port clocks are sampled and turned into edge enables
  bfc_edge edgeA (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .level(portAClock),
    .tick(aTick)
  );
  bfc_edge edgeB (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .level(portBClock),
    .tick(bTick)
  );

  // device reset only with select and both enables idle
  assign devReset = ~masterResetN & portASelectN & portAEnableN & portBEnableN;

  // address decode while selected
  assign aSel = ~portASelectN;
  assign addrFifo = resourceSelect == bfc_pkg::ADDR_FIFO;
  assign addrBypass = resourceSelect == bfc_pkg::ADDR_BYPASS;
  assign addrOffset = resourceSelect[bfc_pkg::ADDR_OFFSET_BIT];
  assign aWrite = aTick & aSel & ~portADir & ~portAEnableN;
  assign aRead = aTick & aSel & portADir & ~portAEnableN;
  assign bWrite = bTick & ~portBDir & ~portBEnableN;
  assign bRead = bTick & portBDir & ~portBEnableN;
  assign offSel = st.offs[resourceSelect[1:0]];

  bfc_fifo #(
    .WIDTH(DW),
    .DEPTH(DEPTH),
    .OW(OW)
  ) fifoA2b (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(devReset),
    .wrTick(aTick),
    .wrEn(aWrite & addrFifo),
    .wrData(portADataIn),
    .rdTick(bTick),
    .rdEn(bRead & st.bypassN),
    .aeOffset(st.offs[bfc_pkg::OFS_A2B_AE]),
    .afOffset(st.offs[bfc_pkg::OFS_A2B_AF]),
    .rdData(a2bData),
    .rdOk(a2bRdOk),
    .emptyN(a2bEmptyN),
    .almostEmptyN(a2bAlmostEmptyN),
    .fullN(a2bFullN),
    .almostFullN(a2bAlmostFullN)
  );

  bfc_fifo #(
    .WIDTH(DW),
    .DEPTH(DEPTH),
    .OW(OW)
  ) fifoB2a (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(devReset),
    .wrTick(bTick),
    .wrEn(bWrite & st.bypassN),
    .wrData(portBDataIn),
    .rdTick(aTick),
    .rdEn(aRead & addrFifo),
    .aeOffset(st.offs[bfc_pkg::OFS_B2A_AE]),
    .afOffset(st.offs[bfc_pkg::OFS_B2A_AF]),
    .rdData(b2aData),
    .rdOk(b2aRdOk),
    .emptyN(b2aEmptyN),
    .almostEmptyN(b2aAlmostEmptyN),
    .fullN(b2aFullN),
    .almostFullN(b2aAlmostFullN)
  );

  always_comb begin
    next_st = st;
    // port A direction is latched on its own edge
    if (aTick && aSel) begin
      next_st.aDir = portADir;
    end
    // drive only when selected, reading and drive enabled
    next_st.aOe = aSel & st.aDir & ~portADriveN;
    if (aWrite) begin
      if (addrOffset) begin
        next_st.offs[resourceSelect[1:0]] = portADataIn[OW-1:0];
      end else if (addrBypass && !st.abFull) begin
        next_st.abWord = portADataIn;
        next_st.abFull = 1'b1;
      end
    end
    if (aRead) begin
      if (addrOffset) begin
        next_st.aOut = DW'(offSel);
      end else if (addrBypass) begin
        if (st.baFull) begin
          next_st.aOut = st.baWord;
          next_st.baFull = 1'b0;
        end
      end else if (addrFifo && b2aRdOk) begin
        next_st.aOut = b2aData;
      end
    end
    // port B side
    if (bTick) begin
      next_st.bypassN = ~(aSel & addrBypass);
      next_st.bDir = portBDir;
    end
    next_st.bOe = st.bDir & ~portBDriveN;
    if (bWrite && !st.bypassN && !st.baFull) begin
      next_st.baWord = portBDataIn;
      next_st.baFull = 1'b1;
    end
    if (bRead) begin
      if (!st.bypassN) begin
        if (st.abFull) begin
          next_st.bOut = st.abWord;
          next_st.abFull = 1'b0;
        end
      end else if (a2bRdOk) begin
        next_st.bOut = a2bData;
      end
    end
    if (devReset) begin
      next_st = ST_RST;
    end
  end

  // every port data, drive and bypass output comes from this register; the fifo flags come from bfc_fifo
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign portADataOut = st.aOut;
  assign portADataOe = st.aOe;
  assign portBDataOut = st.bOut;
  assign portBDataOe = st.bOe;
  assign bypassActiveN = st.bypassN;

  hiz_on_deselect_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    portASelectN |=> !portADataOe)
    else $error("port A drives while deselected");

  write_floats_bus_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (aWrite && !devReset) |=> ##1 !portADataOe)
    else $error("port A still drives after a clocked write");

  bypass_enter_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bTick && aSel && addrBypass && !devReset) |=> !bypassActiveN)
    else $error("bypass indicator missed port B edge");

  bypass_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bTick && portASelectN) |=> bypassActiveN)
    else $error("bypass indicator active while deselected");

  hold_output_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (aTick && aSel && portADir && portAEnableN && !devReset) |=> $stable(portADataOut))
    else $error("port A output changed with enable high");

  offset_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (aRead && addrOffset && !devReset) |=> portADataOut == DW'($past(offSel)))
    else $error("offset read returned wrong value");

  bypass_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (aRead && addrBypass && st.baFull && !devReset) |=> portADataOut == $past(st.baWord) && !st.baFull)
    else $error("bypass read returned wrong word");

  fifo_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (aRead && addrFifo && b2aRdOk && !devReset) |=> portADataOut == $past(b2aData))
    else $error("fifo read returned wrong word");

  reset_defaults_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    devReset |-> ##RSF_CYC (st.offs == {4{bfc_pkg::OFFSET_RST}}) && bypassActiveN)
    else $error("offsets not at default after reset");

  reset_flags_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    devReset |-> ##RSF_CYC !a2bEmptyN && !b2aEmptyN && !a2bAlmostEmptyN && !b2aAlmostEmptyN
      && a2bFullN && b2aFullN && a2bAlmostFullN && b2aAlmostFullN)
    else $error("flags not at reset state");

  bypass_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (aWrite && addrBypass && !st.abFull && !devReset) |=> st.abFull && st.abWord == $past(portADataIn))
    else $error("bypass write from port A not held");

  bypass_b_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bRead && !bypassActiveN && st.abFull && !devReset) |=> portBDataOut == $past(st.abWord) && !st.abFull)
    else $error("port B bypass read returned wrong word");

  offset_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (aWrite && addrOffset && !devReset) |=> st.offs[$past(resourceSelect[1:0])] == $past(portADataIn[OW-1:0]))
    else $error("offset write did not land");

  enable_gates_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (aTick && aSel && portAEnableN && !devReset) |=> st.offs == $past(st.offs))
    else $error("offsets changed with enable high");

  a_drive_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    portADriveN |=> !portADataOe)
    else $error("port A drives with drive enable high");

  b_drive_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    portBDriveN |=> !portBDataOe)
    else $error("port B drives with drive enable high");

  cover_bypass_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    !bypassActiveN ##1 (bRead && st.abFull));
  cover_fifo_read_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    aRead && addrFifo && b2aRdOk);
  cover_offset_write_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    aWrite && addrOffset);
  cover_a2b_full_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    !a2bFullN);
endmodule

// ===== src/bfc_pkg.sv
// constants for the port A control of the two-way fifo buffer
package bfc_pkg;
  localparam int DATA_W = 18;
  localparam int FIFO_DEPTH = 512;
  localparam int OFFSET_W = 9;
  localparam logic [OFFSET_W-1:0] OFFSET_RST = 9'h008;
  localparam logic [2:0] ADDR_FIFO = 3'h0;
  localparam logic [2:0] ADDR_BYPASS = 3'h1;
  localparam int ADDR_OFFSET_BIT = 2;
  localparam logic [1:0] OFS_A2B_AE = 2'h0;
  localparam logic [1:0] OFS_A2B_AF = 2'h1;
  localparam logic [1:0] OFS_B2A_AE = 2'h2;
  localparam logic [1:0] OFS_B2A_AF = 2'h3;
  localparam logic EMPTY_N_RST = 1'b0;
  localparam logic FULL_N_RST = 1'b1;
  localparam logic BYPASS_N_RST = 1'b1;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_TO_FLAGS_NS = 27;
  localparam int RESET_TO_FLAGS_CYC = (RESET_TO_FLAGS_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (RESET_TO_FLAGS_NS / CLK_PERIOD_NS);
endpackage

// ===== src/bfc_edge.sv
// rising edge detector for a port clock sampled on sys_clk
`timescale 1ns/1ps
module bfc_edge (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic level,
  output logic tick
);
  typedef struct packed {
    logic prev;
  } bfc_edge_t;

  bfc_edge_t st;
  bfc_edge_t next_st;

  always_comb begin
    next_st = st;
    next_st.prev = level;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = level & ~st.prev;
endmodule

// ===== src/bfc_fifo.sv
// one direction of fifo storage with pointers and four flags
`timescale 1ns/1ps
module bfc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 512,
  parameter int OW = 9
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wrTick,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdTick,
  input wire logic rdEn,
  input wire logic [OW-1:0] aeOffset,
  input wire logic [OW-1:0] afOffset,
  output logic [WIDTH-1:0] rdData,
  output logic rdOk,
  output logic emptyN,
  output logic almostEmptyN,
  output logic fullN,
  output logic almostFullN
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic emptyN;
    logic almostEmptyN;
    logic fullN;
    logic almostFullN;
  } bfc_fifo_t;

  localparam bfc_fifo_t ST_RST = '{mem: '0, wrPtr: '0, rdPtr: '0,
    emptyN: bfc_pkg::EMPTY_N_RST, almostEmptyN: bfc_pkg::EMPTY_N_RST,
    fullN: bfc_pkg::FULL_N_RST, almostFullN: bfc_pkg::FULL_N_RST};

  bfc_fifo_t st;
  bfc_fifo_t next_st;
  logic [AW:0] count;
  logic [AW:0] nextCount;
  logic isFull;
  logic doWr;
  logic doRd;

  assign count = st.wrPtr - st.rdPtr;
  assign isFull = count == CW'(DEPTH);
  assign rdOk = count != '0;
  assign doWr = wrTick & wrEn & ~isFull;
  assign doRd = rdTick & rdEn & rdOk;
  assign rdData = st.mem[st.rdPtr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (doWr) begin
      next_st.mem[st.wrPtr[AW-1:0]] = wrData;
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (doRd) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    // fill level after this cycle's pointer moves
    nextCount = next_st.wrPtr - next_st.rdPtr;
    // reader side flags move on reader edges only, apart from clear
    if (rdTick) begin
      next_st.emptyN = nextCount != '0;
      next_st.almostEmptyN = {1'b0, nextCount} > (CW + 1)'(aeOffset);
    end
    if (wrTick) begin
      next_st.fullN = nextCount != CW'(DEPTH);
      next_st.almostFullN = ({1'b0, nextCount} + (CW + 1)'(afOffset)) < (CW + 1)'(DEPTH);
    end
    if (clear) begin
      next_st = ST_RST;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign emptyN = st.emptyN;
  assign almostEmptyN = st.almostEmptyN;
  assign fullN = st.fullN;
  assign almostFullN = st.almostFullN;

  reset_ptrs_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clear |=> (st.rdPtr == '0) && (st.wrPtr == '0) && !emptyN && !almostEmptyN && fullN && almostFullN)
    else $error("fifo clear did not restore pointers and flags");
  read_advance_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rdTick && rdEn && rdOk && !clear) |=> st.rdPtr == $past(st.rdPtr) + 1'b1)
    else $error("fifo read pointer did not advance");
  no_overflow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    count <= CW'(DEPTH))
    else $error("fifo holds more words than its depth");
endmodule

// ===== bench/bfc_port_b_model.sv
// port B processor model on the far side of the buffer
`timescale 1ns/1ps
module bfc_port_b_model (
  input wire logic sys_clk,
  output logic portBClock,
  output logic portBDir,
  output logic portBEnableN,
  output logic portBDriveN,
  output logic [bfc_pkg::DATA_W-1:0] portBDataIn
);
  initial begin
    portBClock = 1'b0;
    portBDir = 1'b1;
    portBEnableN = 1'b1;
    portBDriveN = 1'b1;
    portBDataIn = 18'h0;
  end
  // one port B clock pulse after slow idle cycles
  task automatic xfer(input logic en, input logic dir, input logic [bfc_pkg::DATA_W-1:0] word, input int slow);
    repeat (slow) @(posedge sys_clk);
    @(posedge sys_clk);
    #2;
    portBEnableN = !en;
    portBDir = dir;
    portBDriveN = !dir;
    portBDataIn = dir ? ~portBDataIn : word;
    portBClock = 1'b1;
    @(posedge sys_clk);
    #2;
    portBClock = 1'b0;
    @(posedge sys_clk);
    #2;
    portBEnableN = 1'b1;
    portBDataIn = ~portBDataIn;
  endtask
endmodule

// ===== bench/test_bidir_fifo_port_a_control.sv
// self-checking bench for the port A control of the two-way fifo buffer
`timescale 1ns/1ps
module test_bidir_fifo_port_a_control;
  logic sys_clk, resetn, masterResetN, portAClock, portASelectN, portADir, portAEnableN, portADriveN;
  logic [2:0] resourceSelect;
  logic [17:0] portADataIn, portADataOut, portBDataIn, portBDataOut;
  logic portADataOe, portBClock, portBDir, portBEnableN, portBDriveN, portBDataOe, bypassActiveN;
  logic a2bEmptyN, a2bAlmostEmptyN, a2bFullN, a2bAlmostFullN;
  logic b2aEmptyN, b2aAlmostEmptyN, b2aFullN, b2aAlmostFullN;
  logic [7:0] flags;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  assign flags = {a2bEmptyN, a2bAlmostEmptyN, a2bFullN, a2bAlmostFullN,
    b2aEmptyN, b2aAlmostEmptyN, b2aFullN, b2aAlmostFullN};
  bfc_port_a_ctrl bfc_port_a_ctrl_inst (.sys_clk(sys_clk), .resetn(resetn), .masterResetN(masterResetN),
    .portAClock(portAClock), .portASelectN(portASelectN), .portADir(portADir), .portAEnableN(portAEnableN),
    .portADriveN(portADriveN), .resourceSelect(resourceSelect), .portADataIn(portADataIn),
    .portADataOut(portADataOut), .portADataOe(portADataOe), .portBClock(portBClock), .portBDir(portBDir),
    .portBEnableN(portBEnableN), .portBDriveN(portBDriveN), .portBDataIn(portBDataIn),
    .portBDataOut(portBDataOut), .portBDataOe(portBDataOe), .bypassActiveN(bypassActiveN),
    .a2bEmptyN(a2bEmptyN), .a2bAlmostEmptyN(a2bAlmostEmptyN), .a2bFullN(a2bFullN),
    .a2bAlmostFullN(a2bAlmostFullN), .b2aEmptyN(b2aEmptyN), .b2aAlmostEmptyN(b2aAlmostEmptyN),
    .b2aFullN(b2aFullN), .b2aAlmostFullN(b2aAlmostFullN));
  bfc_port_b_model bfc_port_b_model_inst (.sys_clk(sys_clk), .portBClock(portBClock), .portBDir(portBDir),
    .portBEnableN(portBEnableN), .portBDriveN(portBDriveN), .portBDataIn(portBDataIn));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      $display("ERROR timeout expected finish seen hang");
      stop_test();
    end
  end
  task automatic checkWord(input string what, input logic [17:0] exp, input logic [17:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkBit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  // one port A clock pulse; reads drive, writes float
  task automatic aXfer(input logic sel, input logic en, input logic dir, input logic [2:0] addr,
    input logic [17:0] word);
    @(posedge sys_clk);
    #2;
    portASelectN = !sel;
    portAEnableN = !en;
    portADir = dir;
    portADriveN = !dir && portADataOe;
    resourceSelect = addr;
    portADataIn = word;
    portAClock = 1'b1;
    @(posedge sys_clk);
    #2;
    portAClock = 1'b0;
    @(posedge sys_clk);
    #2;
    portAEnableN = 1'b1;
    portADataIn = ~word;
  endtask
  task automatic readOffsets(input logic [17:0] v0, v1, v2, v3);
    logic [17:0] exp [4];
    exp = '{v0, v1, v2, v3};
    for (int i = 0; i < 4; i++) begin
      aXfer(1'b1, 1'b1, 1'b1, 3'h4 + 3'(i), 18'h0);
      checkWord("offset", exp[i], portADataOut);
      checkBit("drive", 1'b1, portADataOe);
    end
  endtask
  task automatic testReset();
    checkWord("flags", 18'h33, {10'h0, flags});
    checkBit("bypass", 1'b1, bypassActiveN);
    readOffsets(18'h8, 18'h8, 18'h8, 18'h8);
    $display("test reset done");
  endtask
  task automatic testOffsets();
    for (int i = 0; i < 4; i++) begin
      aXfer(1'b1, 1'b1, 1'b0, 3'h4 + 3'(i), 18'h2a1c0 + 18'(i * 9));
    end
    @(posedge sys_clk);
    #2;
    checkBit("write float", 1'b0, portADataOe);
    aXfer(1'b0, 1'b1, 1'b0, 3'h4, 18'h00005);
    @(posedge sys_clk);
    #2;
    checkBit("deselect float", 1'b0, portADataOe);
    readOffsets(18'h001c0, 18'h001c9, 18'h001d2, 18'h001db);
    aXfer(1'b0, 1'b0, 1'b1, 3'h0, 18'h0);
    checkBit("deselect after read", 1'b0, portADataOe);
    $display("test offsets done");
  endtask
  task automatic testFifo();
    bfc_port_b_model_inst.xfer(1'b1, 1'b0, 18'h12345, 0);
    bfc_port_b_model_inst.xfer(1'b1, 1'b0, 18'h2abcd, 3);
    aXfer(1'b1, 1'b0, 1'b1, 3'h0, 18'h0);
    checkWord("hold", 18'h001db, portADataOut);
    checkBit("b2a empty", 1'b1, b2aEmptyN);
    aXfer(1'b1, 1'b1, 1'b1, 3'h0, 18'h0);
    checkWord("fifo first", 18'h12345, portADataOut);
    aXfer(1'b1, 1'b1, 1'b1, 3'h0, 18'h0);
    checkWord("fifo second", 18'h2abcd, portADataOut);
    aXfer(1'b1, 1'b1, 1'b1, 3'h0, 18'h0);
    checkWord("fifo empty", 18'h2abcd, portADataOut);
    checkBit("b2a empty", 1'b0, b2aEmptyN);
    aXfer(1'b1, 1'b1, 1'b0, 3'h0, 18'h35a5a);
    bfc_port_b_model_inst.xfer(1'b1, 1'b1, 18'h0, 2);
    checkWord("a2b word", 18'h35a5a, portBDataOut);
    checkBit("b drive", 1'b1, portBDataOe);
    $display("test fifo done");
  endtask
  task automatic testBypass();
    aXfer(1'b1, 1'b0, 1'b1, 3'h1, 18'h0);
    bfc_port_b_model_inst.xfer(1'b0, 1'b1, 18'h0, 0);
    checkBit("bypass on", 1'b0, bypassActiveN);
    bfc_port_b_model_inst.xfer(1'b1, 1'b0, 18'h1f00f, 1);
    checkBit("b float", 1'b0, portBDataOe);
    aXfer(1'b1, 1'b1, 1'b1, 3'h1, 18'h0);
    checkWord("bypass b to a", 18'h1f00f, portADataOut);
    aXfer(1'b1, 1'b1, 1'b0, 3'h1, 18'h0c3c3);
    bfc_port_b_model_inst.xfer(1'b1, 1'b1, 18'h0, 0);
    checkWord("bypass a to b", 18'h0c3c3, portBDataOut);
    aXfer(1'b0, 1'b0, 1'b1, 3'h1, 18'h0);
    bfc_port_b_model_inst.xfer(1'b0, 1'b1, 18'h0, 0);
    checkBit("bypass off", 1'b1, bypassActiveN);
    $display("test bypass done");
  endtask
  task automatic testMasterReset();
    bfc_port_b_model_inst.xfer(1'b1, 1'b0, 18'h00777, 0);
    @(posedge sys_clk);
    #2;
    masterResetN = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2;
    masterResetN = 1'b1;
    aXfer(1'b0, 1'b0, 1'b1, 3'h0, 18'h0);
    checkWord("flags", 18'h33, {10'h0, flags});
    readOffsets(18'h8, 18'h8, 18'h8, 18'h8);
    $display("test master reset done");
  endtask
  initial begin
    resetn = 1'b0;
    masterResetN = 1'b1;
    portAClock = 1'b0;
    portASelectN = 1'b1;
    portADir = 1'b1;
    portAEnableN = 1'b1;
    portADriveN = 1'b1;
    resourceSelect = 3'h0;
    portADataIn = 18'h0;
    repeat (3) @(posedge sys_clk);
    #2;
    resetn = 1'b1;
    testReset();
    testOffsets();
    testFifo();
    testBypass();
    testMasterReset();
    stop_test();
  end
endmodule
